// >>> rtl/tfr_top.sv
// temperature result formatting, diode fault flags and alert pins
// Contract
// - each result is a 13-bit count of sixteenths of a degree.
// - the count sits left-justified in a 16-bit word with the low three bits zero.
// - the word spans -256 to 255.9375 degrees in two's complement.
// - the upper byte weighs two degrees per bit and the lower byte holds the one-degree bit (bit 7) and the fraction.
// - a shorted remote diode reports the most negative word, -256 degrees.
// - the fault comparator is sampled on every cycle of a remote conversion.
// - a fault seen during a remote conversion sets that channel's open-fault flag.
// - one hysteresis value serves both alert outputs.
// - a result word is read out high byte first, then low byte.
`timescale 1ns/10ps
`default_nettype none
module tfr_top
	import tfr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_arst_n,
	input wire logic i_conv_valid,
	input wire logic [3:0] i_conv_chan,
	input wire logic [12:0] i_conv_code,
	input wire logic i_conv_short,
	input wire logic i_remote_busy,
	input wire logic [3:0] i_remote_chan,
	input wire logic i_fault_cmp,
	input wire logic i_flag_clr,
	input wire logic [7:0] i_flag_clr_mask,
	input wire logic [143:0] i_lim_pri,
	input wire logic [143:0] i_lim_sec,
	input wire logic [15:0] i_hyst,
	input wire logic i_rd_req,
	input wire logic i_rd_first,
	input wire logic [3:0] i_rd_ptr,
	output logic [7:0] o_rd_byte,
	output logic o_rd_valid,
	output logic [7:0] o_remote_open_fault_flag,
	output logic o_primary_overtemp_alert,
	output logic o_secondary_overtemp_alert
);
	logic rst_meta_reg;
	logic rst_n_reg;
	logic cmp_meta_reg;
	logic cmp_sync_reg;
	logic [15:0] word_reg [TFR_CH_NUM];
	logic [7:0] flag_reg;
	logic [7:0] flag_set;
	logic [7:0] flag_clr;
	logic lsb_next_reg;
	logic [3:0] rd_ptr_reg;
	tfr_alert_if aif ();

	// reset release through two stages, assertion stays asynchronous
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// comparator is analogue, so bring it in through two stages
	always_ff @(posedge i_mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg <= i_fault_cmp;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	// result store, one word per channel
	// 13-bit code stored
	always_ff @(posedge i_mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			for (int i = 0; i < TFR_CH_NUM; i++)
				word_reg[i] <= TFR_WORD_RST;
		end else if (i_conv_valid && i_conv_chan < TFR_CH_W'(TFR_CH_NUM)) begin
			if (i_conv_short && i_conv_chan != TFR_CH_W'(TFR_LOCAL_CH))
				word_reg[i_conv_chan] <= TFR_SHORT_WORD;
			else
				word_reg[i_conv_chan] <= tfr_fmt(i_conv_code);
		end
	end

	// fault sets and clears; remote channel n is flag bit n-1
	// sample every busy cycle
	always_comb begin
		flag_set = '0;
		flag_clr = i_flag_clr ? i_flag_clr_mask : '0;
		if (i_remote_busy && cmp_sync_reg && i_remote_chan != 4'h0 && i_remote_chan <= 4'h8)
			flag_set[3'(i_remote_chan - 4'h1)] = 1'b1;
	end

	// set wins over a clear in the same cycle so no fault is lost
	// sticky open fault
	always_ff @(posedge i_mclk or negedge rst_n_reg) begin
		if (!rst_n_reg)
			flag_reg <= TFR_FLAG_RST;
		else
			flag_reg <= (flag_reg & ~flag_clr) | flag_set;
	end

	// alert comparator hookup; limits arrive as flat channel slices
	// signed word compare
	always_comb begin
		for (int i = 0; i < TFR_CH_NUM; i++) begin
			aif.temp[i] = word_reg[i];
			aif.lim_pri[i] = i_lim_pri[i*TFR_WORD_W +: TFR_WORD_W];
			aif.lim_sec[i] = i_lim_sec[i*TFR_WORD_W +: TFR_WORD_W];
		end
		aif.hyst = i_hyst;
	end

	tfr_alert u_alert (
		.i_mclk(i_mclk),
		.i_rst_n(rst_n_reg),
		.bus(aif.cmp)
	);

	// byte readout; a first request always restarts at the high byte
	// high byte first
	always_ff @(posedge i_mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_rd_byte <= 8'h00;
			o_rd_valid <= 1'b0;
			lsb_next_reg <= 1'b0;
			rd_ptr_reg <= 4'h0;
		end else begin
			o_rd_valid <= i_rd_req;
			if (i_rd_req) begin
				if (i_rd_first || !lsb_next_reg) begin
					rd_ptr_reg <= i_rd_first ? i_rd_ptr : rd_ptr_reg;
					o_rd_byte <= (i_rd_first ? i_rd_ptr : rd_ptr_reg) < TFR_CH_W'(TFR_CH_NUM)
						? word_reg[i_rd_first ? i_rd_ptr : rd_ptr_reg][15:8] : 8'h00;
					lsb_next_reg <= 1'b1;
				end else begin
					o_rd_byte <= rd_ptr_reg < TFR_CH_W'(TFR_CH_NUM) ? word_reg[rd_ptr_reg][7:0] : 8'h00;
					lsb_next_reg <= 1'b0;
				end
			end
		end
	end

	// pins and flags straight from flops
	always_ff @(posedge i_mclk or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			o_primary_overtemp_alert <= 1'b0;
			o_secondary_overtemp_alert <= 1'b0;
			o_remote_open_fault_flag <= TFR_FLAG_RST;
		end else begin
			o_primary_overtemp_alert <= aif.pri_any;
			o_secondary_overtemp_alert <= aif.sec_any;
			o_remote_open_fault_flag <= flag_reg;
		end
	end

	sequence s_conv_short;
		i_conv_valid && i_conv_short && i_conv_chan != 4'h0 && i_conv_chan < 4'h9;
	endsequence
	sequence s_conv_norm;
		i_conv_valid && !i_conv_short && i_conv_chan < 4'h9;
	endsequence

	AST_SHORT_MIN: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		s_conv_short |=> word_reg[$past(i_conv_chan)] == 16'h8000)
		else $error("short did not give minimum word");
	AST_FMT_WORD: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		s_conv_norm |=> word_reg[$past(i_conv_chan)] == {$past(i_conv_code), 3'h0})
		else $error("result word not left justified");
	AST_LOW_ZERO: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		word_reg[1][2:0] == 3'h0 && word_reg[0][2:0] == 3'h0)
		else $error("low result bits not zero");
	AST_FAULT_SET: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		i_remote_busy && cmp_sync_reg && i_remote_chan == 4'h3 |=> flag_reg[2] ##1 o_remote_open_fault_flag[2])
		else $error("open fault flag not set");
	// remote channel 3 is the one the fault stimulus trips
	AST_FAULT_STICKY: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		flag_reg[2] && !(i_flag_clr && i_flag_clr_mask[2]) |=> flag_reg[2])
		else $error("fault flag lost without clear");
	AST_MSB_FIRST: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		i_rd_req && i_rd_first && i_rd_ptr < 4'h9 |=> o_rd_valid && o_rd_byte == $past(word_reg[i_rd_ptr][15:8]))
		else $error("first byte is not the high byte");
	AST_LSB_SECOND: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		i_rd_req && !i_rd_first && lsb_next_reg && rd_ptr_reg < 4'h9
		|=> o_rd_byte == $past(word_reg[rd_ptr_reg][7:0]))
		else $error("second byte is not the low byte");
	AST_PIN_FOLLOW: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		aif.pri_any |=> o_primary_overtemp_alert)
		else $error("primary pin does not follow alert state");
	// word is written on the edge that takes the result, so look one edge later
	AST_RANGE_SIGN: assert property (@(posedge i_mclk) disable iff (!rst_n_reg)
		s_conv_norm |=> word_reg[$past(i_conv_chan)][15] == $past(i_conv_code[12]))
		else $error("sign bit not carried");
endmodule
`default_nettype wire

// >>> rtl/tfr_pkg.sv
// shared constants for the temperature result formatter
package tfr_pkg;
	localparam int unsigned TFR_CH_NUM = 9;
	localparam int unsigned TFR_CH_W = 4;
	localparam int unsigned TFR_LOCAL_CH = 0;
	localparam int unsigned TFR_REM_NUM = 8;
	localparam int unsigned TFR_CODE_W = 13;
	localparam int unsigned TFR_WORD_W = 16;
	localparam int unsigned TFR_PAD_W = 3;
	localparam int unsigned TFR_BYTE_W = 8;
	localparam logic [15:0] TFR_SHORT_WORD = 16'h8000;
	localparam logic [15:0] TFR_WORD_RST = 16'h0000;
	localparam logic [7:0] TFR_FLAG_RST = 8'h00;
	localparam logic [15:0] TFR_HYST_RST = 16'h0000;

	// left-justify the 13-bit code, low three bits zero
	function automatic logic [15:0] tfr_fmt(input logic [12:0] code);
		tfr_fmt = {code, 3'h0};
	endfunction

	// sign-extended difference limit minus hysteresis
	function automatic logic signed [16:0] tfr_release(input logic [15:0] lim, input logic [15:0] hyst);
		tfr_release = $signed({lim[15], lim}) - $signed({1'b0, hyst});
	endfunction
endpackage

// >>> rtl/tfr_alert_if.sv
// carrier between result store and alert comparators
`timescale 1ns/10ps
`default_nettype none
interface tfr_alert_if;
	import tfr_pkg::*;
	logic [15:0] temp [TFR_CH_NUM];
	logic [15:0] lim_pri [TFR_CH_NUM];
	logic [15:0] lim_sec [TFR_CH_NUM];
	logic [15:0] hyst;
	logic pri_any;
	logic sec_any;
	modport core (output temp, output lim_pri, output lim_sec, output hyst, input pri_any, input sec_any);
	modport cmp (input temp, input lim_pri, input lim_sec, input hyst, output pri_any, output sec_any);
endinterface
`default_nettype wire

// >>> rtl/tfr_alert.sv
// hysteresis comparators for both overtemperature alerts
`timescale 1ns/10ps
`default_nettype none
module tfr_alert
	import tfr_pkg::*;
(
	input wire logic i_mclk,
	input wire logic i_rst_n,
	tfr_alert_if.cmp bus
);
	logic [TFR_CH_NUM-1:0] pri_reg;
	logic [TFR_CH_NUM-1:0] sec_reg;

	// set above limit, hold until below limit minus hysteresis
	// set and release
	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pri_reg <= '0;
			sec_reg <= '0;
		end else begin
			for (int i = 0; i < TFR_CH_NUM; i++) begin
				if ($signed(bus.temp[i]) > $signed(bus.lim_pri[i]))
					pri_reg[i] <= 1'b1;
				else if ($signed({bus.temp[i][15], bus.temp[i]}) < tfr_release(bus.lim_pri[i], bus.hyst))
					pri_reg[i] <= 1'b0;
				if ($signed(bus.temp[i]) > $signed(bus.lim_sec[i]))
					sec_reg[i] <= 1'b1;
				else if ($signed({bus.temp[i][15], bus.temp[i]}) < tfr_release(bus.lim_sec[i], bus.hyst))
					sec_reg[i] <= 1'b0;
			end
		end
	end

	// any channel drives the shared pin
	assign bus.pri_any = |pri_reg;
	assign bus.sec_any = |sec_reg;

	// one set of checks per channel, so whichever channel trips is watched
	for (genvar g = 0; g < TFR_CH_NUM; g++) begin : g_chk
		AST_PRI_SET: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
			$signed(bus.temp[g]) > $signed(bus.lim_pri[g]) |=> pri_reg[g])
			else $error("primary alert not set above limit");
		AST_SEC_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
			sec_reg[g] && $signed({bus.temp[g][15], bus.temp[g]}) >= tfr_release(bus.lim_sec[g], bus.hyst)
			|=> sec_reg[g])
			else $error("secondary alert released inside hysteresis band");
		AST_PRI_REL: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
			$fell(pri_reg[g]) |-> $signed({$past(bus.temp[g][15]), $past(bus.temp[g])})
			< tfr_release($past(bus.lim_pri[g]), $past(bus.hyst)))
			else $error("primary alert released without cause");
	end
endmodule
`default_nettype wire

// >>> sim/tfr_rd_ctrl.sv
// two-wire controller model fetching result words one byte at a time
`timescale 1ns/10ps
`default_nettype none
module tfr_rd_ctrl (
	input wire logic i_mclk,
	input wire logic i_rd_valid,
	input wire logic [7:0] i_rd_byte,
	output logic o_rd_req,
	output logic o_rd_first,
	output logic [3:0] o_rd_ptr
);
	// idle controller at time zero
	initial begin
		o_rd_req = 1'b0;
		o_rd_first = 1'b0;
		o_rd_ptr = 4'h0;
	end

	// one byte request; a missing answer returns unknowns so it cannot match
	// an idle edge first, so the strobe is never dropped and raised in one step
	task automatic fetch(input logic first, output logic [7:0] b);
		int n;
		@(negedge i_mclk);
		o_rd_req = 1'b1;
		o_rd_first = first;
		@(negedge i_mclk);
		o_rd_req = 1'b0;
		o_rd_first = ~first;
		n = 0;
		while (i_rd_valid !== 1'b1 && n < 4) begin
			@(negedge i_mclk);
			n++;
		end
		b = (i_rd_valid === 1'b1) ? i_rd_byte : 8'hxx;
	endtask

	task automatic read_word(input logic [3:0] ptr, output logic [15:0] w);
		logic [7:0] hi;
		logic [7:0] lo;
		o_rd_ptr = ptr;
		fetch(1'b1, hi);
		o_rd_ptr = ~ptr; // pointer only sampled on first byte
		fetch(1'b0, lo);
		w = {hi, lo};
	endtask
endmodule
`default_nettype wire

// >>> sim/temp_result_format_and_fault_tb.sv
// self-checking bench for the temperature result formatter
`timescale 1ns/10ps
`default_nettype none
module temp_result_format_and_fault_tb;
	import tfr_pkg::*;
	logic i_mclk, i_arst_n, i_conv_valid, i_conv_short, i_remote_busy, i_fault_cmp, i_flag_clr;
	logic [3:0] i_conv_chan, i_remote_chan, i_rd_ptr;
	logic [12:0] i_conv_code;
	logic [7:0] i_flag_clr_mask, o_rd_byte, o_remote_open_fault_flag;
	logic [143:0] i_lim_pri, i_lim_sec;
	logic [15:0] i_hyst, w;
	logic i_rd_req, i_rd_first, o_rd_valid, o_primary_overtemp_alert, o_secondary_overtemp_alert;
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;
	logic [12:0] codes [6] = '{13'h0001, 13'h0010, 13'h0fff, 13'h1000, 13'h1fff, 13'h0190};
	logic [15:0] words [6] = '{16'h0008, 16'h0080, 16'h7ff8, 16'h8000, 16'hfff8, 16'h0c80};
	logic [12:0] acode [4] = '{13'h0190, 13'h01a0, 13'h0170, 13'h016f};
	logic aexp [4] = '{1'b0, 1'b1, 1'b1, 1'b0};

	tfr_top u_dut (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_conv_valid(i_conv_valid),
		.i_conv_chan(i_conv_chan), .i_conv_code(i_conv_code), .i_conv_short(i_conv_short),
		.i_remote_busy(i_remote_busy), .i_remote_chan(i_remote_chan), .i_fault_cmp(i_fault_cmp),
		.i_flag_clr(i_flag_clr), .i_flag_clr_mask(i_flag_clr_mask), .i_lim_pri(i_lim_pri),
		.i_lim_sec(i_lim_sec), .i_hyst(i_hyst), .i_rd_req(i_rd_req), .i_rd_first(i_rd_first),
		.i_rd_ptr(i_rd_ptr), .o_rd_byte(o_rd_byte), .o_rd_valid(o_rd_valid),
		.o_remote_open_fault_flag(o_remote_open_fault_flag),
		.o_primary_overtemp_alert(o_primary_overtemp_alert),
		.o_secondary_overtemp_alert(o_secondary_overtemp_alert));
	tfr_rd_ctrl u_ctl (.i_mclk(i_mclk), .i_rd_valid(o_rd_valid), .i_rd_byte(o_rd_byte),
		.o_rd_req(i_rd_req), .o_rd_first(i_rd_first), .o_rd_ptr(i_rd_ptr));

	// 200 MHz clock
	initial begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	// hang guard, run needs well under a thousand cycles
	always @(posedge i_mclk) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end

	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask

	// one result pulse, then three edges so the alert pins settle
	task automatic conv(input logic [3:0] ch, input logic [12:0] code, input logic sh);
		i_conv_valid = 1'b1;
		i_conv_chan = ch;
		i_conv_code = code;
		i_conv_short = sh;
		@(negedge i_mclk);
		i_conv_valid = 1'b0;
		i_conv_code = ~code;
		repeat (3) @(negedge i_mclk);
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// main sequence, inputs change on falling edges
	initial begin
		{i_arst_n, i_conv_valid, i_conv_short, i_remote_busy, i_fault_cmp, i_flag_clr} = '0;
		{i_conv_chan, i_remote_chan, i_conv_code, i_flag_clr_mask, i_hyst} = '0;
		i_lim_pri = {9{16'h7ff8}};
		i_lim_sec = {9{16'h7ff8}};
		repeat (20) @(negedge i_mclk);
		chk("reset_outs", 16'h0000, {o_remote_open_fault_flag, o_rd_valid, o_primary_overtemp_alert});
		i_arst_n = 1'b1;
		repeat (4) @(negedge i_mclk);
		// one shared hysteresis of two degrees, each alert in turn
		i_hyst = 16'h0100;
		for (int a = 0; a < 2; a++) begin
			if (a == 0) i_lim_pri[16 +: 16] = 16'h0c80;
			else i_lim_sec[32 +: 16] = 16'h0c80;
			for (int k = 0; k < 4; k++) begin
				conv(4'(a + 1), acode[k], 1'b0);
				chk("alert_pins", {14'h0, aexp[k] & (a == 0), aexp[k] & (a == 1)},
					{14'h0, o_primary_overtemp_alert, o_secondary_overtemp_alert});
			end
		end
		// codes across the whole span, left-justified words
		for (int k = 0; k < 6; k++) conv(4'(k), codes[k], 1'b0);
		for (int k = 0; k < 6; k++) begin
			u_ctl.read_word(4'(k), w);
			chk("result_word", words[k], w);
		end
		conv(4'h6, 13'h0190, 1'b1);
		u_ctl.read_word(4'h6, w);
		chk("short_word", 16'h8000, w);
		conv(4'h0, 13'h0190, 1'b1);
		u_ctl.read_word(4'h0, w);
		chk("local_short", 16'h0c80, w);
		u_ctl.read_word(4'h9, w);
		chk("bad_ptr", 16'h0000, w);
		// brief fault mid-conversion, then comparator high while idle
		i_remote_busy = 1'b1;
		i_remote_chan = 4'h3;
		repeat (3) @(negedge i_mclk);
		i_fault_cmp = 1'b1;
		repeat (2) @(negedge i_mclk);
		i_fault_cmp = 1'b0;
		repeat (6) @(negedge i_mclk);
		i_remote_busy = 1'b0;
		i_remote_chan = 4'h6;
		i_fault_cmp = 1'b1;
		repeat (6) @(negedge i_mclk);
		i_fault_cmp = 1'b0;
		chk("open_flag", 16'h0004, {8'h0, o_remote_open_fault_flag});
		i_flag_clr = 1'b1;
		i_flag_clr_mask = 8'h04;
		@(negedge i_mclk);
		i_flag_clr = 1'b0;
		repeat (3) @(negedge i_mclk);
		chk("flag_clear", 16'h0000, {8'h0, o_remote_open_fault_flag});
		results();
	end
endmodule
`default_nettype wire
